// ===== design/ssl_latch_loader.sv
// Serial latch loader core: pin sampling, latch decode, reset pulse and power-down.
`timescale 1ns/1ps
module ssl_latch_loader
    import ssl_pkg::*;
#(
    parameter int WORD_W = SSL_WORD_W
)
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              ser_clk,
    input  wire logic              ser_data,
    input  wire logic              load_strobe,
    input  wire logic              chip_enable,
    output logic                   charge_pump_hiz,
    output logic                   counter_hold,
    output logic                   counter_reset_pulse,
    output logic                   power_down,
    output logic                   bias_settled,
    output logic      [WORD_W-1:0] ref_latch,
    output logic      [WORD_W-1:0] fb_latch,
    output logic      [WORD_W-1:0] func_latch
);

    // ----------------------------------------------------------------
    // Pin sampling and edge detection
    // ----------------------------------------------------------------
    logic [3:0]        pins_s;
    logic              sclk_s;
    logic              sdat_s;
    logic              ls_s;
    logic              ce_s;
    logic              sclk_q;
    logic              sclk_d;
    logic              ls_q;
    logic              ls_d;
    logic              sclk_rise;
    logic              ls_rise;
    logic [WORD_W-1:0] word;

    ssl_sync #(
        .W (4)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({ser_clk, ser_data, load_strobe, chip_enable}),
        .q       (pins_s)
    );

    // Synchronised copies of the four serial pins.
    assign sclk_s = pins_s[3];
    assign sdat_s = pins_s[2];
    assign ls_s   = pins_s[1];
    assign ce_s   = pins_s[0];

    // Previous samples of clock and strobe for edge finding.
    always_comb
    begin
        sclk_d = sclk_s;
        ls_d   = ls_s;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sclk_q <= 1'b0;
            ls_q   <= 1'b0;
        end
        else
        begin
            sclk_q <= sclk_d;
            ls_q   <= ls_d;
        end
    end

    // ----------------------------------------------------------------
    // Control register and input shifter
    // ----------------------------------------------------------------
    logic ctrl_en_q;
    logic ctrl_en_d;
    logic serial_en;
    logic load_ev;
    logic upd_ref;
    logic upd_fb;
    logic upd_func;
    logic upd_init;
    logic apb_wr;
    ssl_sel_t sel;

    assign serial_en = ctrl_en_q;
    assign sclk_rise = sclk_s & ~sclk_q;
    assign ls_rise   = ls_s & ~ls_q;

    ssl_shift #(
        .W (WORD_W)
    ) u_shift (
        .pclk     (pclk),
        .presetn  (presetn),
        .shift_en (sclk_rise & serial_en),
        .sdata    (sdat_s),
        .word_q   (word)
    );

    // Strobe rise decodes the select bits of the collected word.
    always_comb
    begin
        sel     = ssl_sel_t'(word[SSL_SEL_LSB +: SSL_SEL_W]);
        load_ev = ls_rise & serial_en;
        upd_ref  = load_ev && (sel == SSL_SEL_REF);
        upd_fb   = load_ev && (sel == SSL_SEL_FB);
        upd_func = load_ev && (sel == SSL_SEL_FUNC);
        upd_init = load_ev && (sel == SSL_SEL_INIT);
    end

    // ----------------------------------------------------------------
    // Programmed latches, reset pulse and power-down
    // ----------------------------------------------------------------
    logic [WORD_W-1:0] ref_q;
    logic [WORD_W-1:0] ref_d;
    logic [WORD_W-1:0] fb_q;
    logic [WORD_W-1:0] fb_d;
    logic [WORD_W-1:0] func_q;
    logic [WORD_W-1:0] func_d;
    logic              armed_q;
    logic              armed_d;
    logic              pulse_q;
    logic              pulse_d;
    logic              spd_q;
    logic              spd_d;
    logic              pd_q;
    logic              pd_d;
    logic              hold_q;
    logic              hold_d;
    logic              hiz_q;
    logic              hiz_d;

    // Latches change only on a strobe event; power-down never clears them.
    always_comb
    begin
        ref_d   = ref_q;
        fb_d    = fb_q;
        func_d  = func_q;
        armed_d = armed_q;
        pulse_d = 1'b0;
        spd_d   = spd_q;
        if (upd_ref)
        begin
            ref_d = word;
        end
        if (upd_fb)
        begin
            fb_d = word;
            if (armed_q)
            begin
                pulse_d = 1'b1;
                armed_d = 1'b0;
            end
        end
        if (upd_func || upd_init)
        begin
            func_d = word;
        end
        if (upd_init)
        begin
            pulse_d = 1'b1;
            armed_d = 1'b1;
        end
        // Programmed power-down ends when bit three (PWRDN1) is written low or enable drops.
        if (!ce_s || ((upd_func || upd_init) && !word[SSL_PWRDN1_BIT]))
        begin
            spd_d = 1'b0;
        end
        // The set is placed last so it wins over a clear in the same cycle.
        if (pulse_q && ce_s && func_q[SSL_PWRDN1_BIT] && !func_q[SSL_PWRDN2_BIT])
        begin
            spd_d = 1'b1;
        end
        pd_d   = !ce_s || spd_d;
        hold_d = pulse_d || func_d[SSL_CLEAR_BIT] || pd_d;
        hiz_d  = hold_d || func_d[SSL_TRI_BIT];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ref_q   <= SSL_LATCH_RST;
            fb_q    <= SSL_LATCH_RST;
            func_q  <= SSL_LATCH_RST;
            armed_q <= 1'b0;
            pulse_q <= 1'b0;
            spd_q   <= 1'b0;
            pd_q    <= 1'b1;
            hold_q  <= 1'b1;
            hiz_q   <= 1'b1;
        end
        else
        begin
            ref_q   <= ref_d;
            fb_q    <= fb_d;
            func_q  <= func_d;
            armed_q <= armed_d;
            pulse_q <= pulse_d;
            spd_q   <= spd_d;
            pd_q    <= pd_d;
            hold_q  <= hold_d;
            hiz_q   <= hiz_d;
        end
    end

    // ----------------------------------------------------------------
    // Bias settling timer and load counter
    // ----------------------------------------------------------------
    localparam logic [SSL_SETTLE_W-1:0] SETTLE_MAX = SSL_SETTLE_W'(SSL_SETTLE_CYC);

    logic [SSL_SETTLE_W-1:0] settle_q;
    logic [SSL_SETTLE_W-1:0] settle_d;
    logic [SSL_LOADS_W-1:0]  loads_q;
    logic [SSL_LOADS_W-1:0]  loads_d;

    // Settling restarts each time chip enable is low; loads wrap silently.
    always_comb
    begin
        settle_d = settle_q;
        loads_d  = loads_q;
        if (!ce_s)
        begin
            settle_d = '0;
        end
        else if (settle_q != SETTLE_MAX)
        begin
            settle_d = settle_q + SSL_SETTLE_W'(1);
        end
        if (load_ev)
        begin
            loads_d = loads_q + SSL_LOADS_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            settle_q <= '0;
            loads_q  <= '0;
        end
        else
        begin
            settle_q <= settle_d;
            loads_q  <= loads_d;
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    logic        mapped;
    logic [31:0] rdata_d;
    logic [31:0] prdata_q;

    // Read data is captured in the setup phase and stands through access.
    always_comb
    begin
        mapped  = 1'b1;
        rdata_d = prdata_q;
        apb_wr  = psel && penable && pwrite;
        unique case (paddr)
            SSL_OFS_CTRL:   rdata_d = {31'h0, ctrl_en_q};
            SSL_OFS_STATUS: rdata_d = {25'h0, ce_s, bias_settled, hold_q, hiz_q,
                                       armed_q, spd_q, pd_q};
            SSL_OFS_REF:    rdata_d = {8'h0, ref_q};
            SSL_OFS_FB:     rdata_d = {8'h0, fb_q};
            SSL_OFS_FUNC:   rdata_d = {8'h0, func_q};
            SSL_OFS_WORD:   rdata_d = {8'h0, word};
            SSL_OFS_LOADS:  rdata_d = {16'h0, loads_q};
            default:
            begin
                mapped  = 1'b0;
                rdata_d = 32'h00000000;
            end
        endcase
        ctrl_en_d = ctrl_en_q;
        if (apb_wr && paddr == SSL_OFS_CTRL)
        begin
            ctrl_en_d = pwdata[SSL_CTRL_EN_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_en_q <= SSL_CTRL_RST;
            prdata_q  <= 32'h00000000;
        end
        else
        begin
            ctrl_en_q <= ctrl_en_d;
            if (psel && !penable)
            begin
                prdata_q <= rdata_d;
            end
        end
    end

    // Outputs: zero wait states, error on unmapped addresses.
    assign pready              = 1'b1;
    assign pslverr             = psel && penable && !mapped;
    assign prdata              = prdata_q;
    assign charge_pump_hiz     = hiz_q;
    assign counter_hold        = hold_q;
    assign counter_reset_pulse = pulse_q;
    assign power_down          = pd_q;
    assign bias_settled        = (settle_q == SETTLE_MAX);
    assign ref_latch           = ref_q;
    assign fb_latch            = fb_q;
    assign func_latch          = func_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_init_load;
        upd_init;
    endsequence

    sequence s_pulse_then_pd;
        counter_reset_pulse ##1 power_down;
    endsequence

    property p_pump_tristate;
        func_q[SSL_TRI_BIT] |-> charge_pump_hiz;
    endproperty
    a_pump_tristate: assert property (p_pump_tristate) else $error("pump not three-stated");

    property p_init_func;
        s_init_load |=> (func_latch == $past(word)) && (ref_latch == $past(ref_latch));
    endproperty
    a_init_func: assert property (p_init_func) else $error("init word not in function latch");

    property p_init_pulse;
        s_init_load |=> counter_reset_pulse && counter_hold ##1 !counter_reset_pulse;
    endproperty
    a_init_pulse: assert property (p_init_pulse) else $error("init pulse missing");

    property p_sync_pd;
        s_init_load ##0 (ce_s && word[SSL_PWRDN1_BIT] && !word[SSL_PWRDN2_BIT])
            ##1 ce_s |-> s_pulse_then_pd;
    endproperty
    a_sync_pd: assert property (p_sync_pd) else $error("sync power-down not started");

    property p_pulse_forces;
        counter_reset_pulse |-> counter_hold && charge_pump_hiz;
    endproperty
    a_pulse_forces: assert property (p_pulse_forces) else $error("pulse did not force");

    property p_fb_first;
        upd_fb && armed_q |=> counter_reset_pulse && !armed_q;
    endproperty
    a_fb_first: assert property (p_fb_first) else $error("first fb load lost pulse");

    property p_fb_later;
        upd_fb && !armed_q |=> !counter_reset_pulse;
    endproperty
    a_fb_later: assert property (p_fb_later) else $error("later fb load pulsed");

    property p_ref_decode;
        upd_ref |=> (ref_latch == $past(word)) && $stable(fb_latch) && $stable(func_latch);
    endproperty
    a_ref_decode: assert property (p_ref_decode) else $error("ref decode wrong");

    property p_ce_down;
        !ce_s |=> power_down;
    endproperty
    a_ce_down: assert property (p_ce_down) else $error("enable low not powered down");

    property p_ce_up;
        $rose(ce_s) && !spd_q |=> !power_down;
    endproperty
    a_ce_up: assert property (p_ce_up) else $error("no power-up on enable");

    property p_retain;
        $changed(ce_s) && !load_ev |=> $stable(ref_latch) && $stable(fb_latch);
    endproperty
    a_retain: assert property (p_retain) else $error("latch lost on enable");

    property p_clear;
        func_q[SSL_CLEAR_BIT] && !pulse_q && !spd_q |-> (counter_hold && charge_pump_hiz)
            ##1 !spd_q;
    endproperty
    a_clear: assert property (p_clear) else $error("clear bit misbehaved");

    property p_shift;
        sclk_rise && serial_en |=> word[0] == $past(sdat_s);
    endproperty
    a_shift: assert property (p_shift) else $error("serial bit not shifted");

    property p_hold_latches;
        !load_ev |=> $stable(ref_latch) && $stable(fb_latch) && $stable(func_latch);
    endproperty
    a_hold_latches: assert property (p_hold_latches) else $error("latch changed w/o strobe");

endmodule

// ===== design/ssl_pkg.sv
// Shared constants for the synthesizer serial latch loader.
package ssl_pkg;

    // ----------------------------------------------------------------
    // Serial word layout
    // ----------------------------------------------------------------
    localparam int SSL_WORD_W     = 24;
    localparam int SSL_SEL_LSB    = 0;
    localparam int SSL_SEL_W      = 2;
    localparam int SSL_CLEAR_BIT  = 2;
    localparam int SSL_PWRDN1_BIT = 3;
    localparam int SSL_TRI_BIT    = 8;
    localparam int SSL_PWRDN2_BIT = 21;

    // Latch selection codes carried in the two low word bits.
    typedef enum logic [1:0] {
        SSL_SEL_REF  = 2'h0,
        SSL_SEL_FB   = 2'h1,
        SSL_SEL_FUNC = 2'h2,
        SSL_SEL_INIT = 2'h3
    } ssl_sel_t;

    // ----------------------------------------------------------------
    // Register map, byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] SSL_OFS_CTRL   = 8'h00;
    localparam logic [7:0] SSL_OFS_STATUS = 8'h04;
    localparam logic [7:0] SSL_OFS_REF    = 8'h08;
    localparam logic [7:0] SSL_OFS_FB     = 8'h0C;
    localparam logic [7:0] SSL_OFS_FUNC   = 8'h10;
    localparam logic [7:0] SSL_OFS_WORD   = 8'h14;
    localparam logic [7:0] SSL_OFS_LOADS  = 8'h18;

    localparam int          SSL_CTRL_EN_BIT = 0;
    localparam logic        SSL_CTRL_RST    = 1'b1;
    localparam logic [23:0] SSL_LATCH_RST   = 24'h000000;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int SSL_PCLK_MHZ   = 250;
    localparam int SSL_SETTLE_NS  = 1000;
    localparam int SSL_SETTLE_CYC = SSL_SETTLE_NS * SSL_PCLK_MHZ / 1000;
    localparam int SSL_SETTLE_W   = 9;
    localparam int SSL_LOADS_W    = 16;

endpackage

// ===== design/ssl_sync.sv
// Two-flop synchroniser for the serial pins.
`timescale 1ns/1ps
module ssl_sync
    import ssl_pkg::*;
#(
    parameter int W = 4
)
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] q_d;

    // First stage feeds only the second stage.
    always_comb
    begin
        meta_d = d;
        q_d    = meta_q;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= '0;
            q      <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            q      <= q_d;
        end
    end

endmodule

// ===== design/ssl_shift.sv
// Input shift register that collects serial data most significant bit first.
`timescale 1ns/1ps
module ssl_shift
    import ssl_pkg::*;
#(
    parameter int W = SSL_WORD_W
)
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         shift_en,
    input  wire logic         sdata,
    output logic      [W-1:0] word_q
);

    logic [W-1:0] word_d;

    // New bits enter at the bottom so the select bits arrive last.
    always_comb
    begin
        word_d = word_q;
        if (shift_en)
        begin
            word_d = {word_q[W-2:0], sdata};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            word_q <= '0;
        end
        else
        begin
            word_q <= word_d;
        end
    end

endmodule

// ===== testbench/ssl_host.sv
// Host model that shifts 24-bit words into the serial pins.
`timescale 1ns/1ps
module ssl_host
(
    input  wire logic pclk,
    output logic      ser_clk,
    output logic      ser_data,
    output logic      load_strobe
);
    // Pins start low; the serial clock stands still between frames.
    initial
    begin
        ser_clk     = 1'b0;
        ser_data    = 1'b0;
        load_strobe = 1'b0;
    end

    // Sends one word, 32 ns per bit, then pulses the strobe if asked.
    task automatic send(input logic [23:0] word, input logic strobe);
        for (int i = 23; i >= 0; i--)
        begin
            ser_data <= word[i];
            repeat (4) @(posedge pclk);
            ser_clk <= 1'b1;
            repeat (4) @(posedge pclk);
            ser_clk <= 1'b0;
        end
        ser_data <= ~word[0];
        repeat (4) @(posedge pclk);
        if (strobe)
        begin
            load_strobe <= 1'b1;
            repeat (8) @(posedge pclk);
            load_strobe <= 1'b0;
        end
    endtask
endmodule

// ===== testbench/tb.sv
// Self-checking testbench for the serial latch loader.
`timescale 1ns/1ps
module tb;
    import ssl_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ser_clk, ser_data;
    logic        load_strobe, chip_enable, charge_pump_hiz, counter_hold, counter_reset_pulse;
    logic        power_down, bias_settled, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [23:0] ref_latch, fb_latch, func_latch, wd;
    int          error_cnt, n_checks, pulse_cnt;

    ssl_latch_loader i_ssl_latch_loader (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ser_clk(ser_clk), .ser_data(ser_data),
        .load_strobe(load_strobe), .chip_enable(chip_enable),
        .charge_pump_hiz(charge_pump_hiz), .counter_hold(counter_hold),
        .counter_reset_pulse(counter_reset_pulse), .power_down(power_down),
        .bias_settled(bias_settled), .ref_latch(ref_latch), .fb_latch(fb_latch),
        .func_latch(func_latch));
    ssl_host i_ssl_host (.pclk(pclk), .ser_clk(ser_clk), .ser_data(ser_data),
        .load_strobe(load_strobe));

    // Clock of 4 ns period.
    always #2 pclk = ~pclk;

    // Counts the cycles in which the reset pulse is high.
    always @(posedge pclk)
    begin
        if (counter_reset_pulse === 1'b1)
            pulse_cnt++;
    end

    // Compares a seen value with its expectation.
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer, held until pready is sampled high.
    task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Builds a latch word from its fields.
    function automatic logic [23:0] w(input logic [1:0] sel, input logic clr, input logic dn1,
                                      input logic dn2, input logic hiz, input logic [11:0] pay);
        logic [23:0] v;
        v = 24'h000000;
        v[20:9] = pay;
        v[SSL_SEL_LSB +: SSL_SEL_W] = sel;
        v[SSL_CLEAR_BIT] = clr;
        v[SSL_PWRDN1_BIT] = dn1;
        v[SSL_PWRDN2_BIT] = dn2;
        v[SSL_TRI_BIT] = hiz;
        return v;
    endfunction

    // Sends a word with its strobe and lets the transfer land.
    task automatic xfer(input logic [23:0] v);
        @(posedge pclk);
        i_ssl_host.send(v, 1'b1);
        repeat (8) @(posedge pclk);
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_sim;
        $display("Counts: %0d checks, %0d mismatches", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Watchdog that cuts a hang short.
    initial
    begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        end_sim();
    end

    // Main test sequence.
    initial
    begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
        pwdata = 32'h0; chip_enable = 0; error_cnt = 0; n_checks = 0; pulse_cnt = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("power_down", power_down, 32'h1);
        apb(SSL_OFS_CTRL, 1'b0, 32'h0);
        chk("ctrl", rd, 32'h1);
        apb(SSL_OFS_REF, 1'b1, 32'hFFFFFF);
        apb(SSL_OFS_REF, 1'b0, 32'h0);
        chk("ref ro", rd, 32'h0);
        apb(8'h1C, 1'b0, 32'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        $display("Test registers done");
        // Chip-enable method: program with enable low, then raise it.
        xfer(w(2'h2, 0, 0, 0, 0, 12'h5A5));
        xfer(w(2'h0, 0, 0, 0, 0, 12'h123));
        xfer(w(2'h1, 0, 0, 0, 0, 12'h3C3));
        chk("func", {8'h0, func_latch}, {8'h0, w(2'h2, 0, 0, 0, 0, 12'h5A5)});
        chk("ref", {8'h0, ref_latch}, {8'h0, w(2'h0, 0, 0, 0, 0, 12'h123)});
        chk("fb", {8'h0, fb_latch}, {8'h0, w(2'h1, 0, 0, 0, 0, 12'h3C3)});
        chk("pd held", power_down, 32'h1);
        apb(SSL_OFS_REF, 1'b0, 32'h0);
        chk("ref read", rd, {8'h0, w(2'h0, 0, 0, 0, 0, 12'h123)});
        chip_enable <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("pd off", power_down, 32'h0);
        chk("bias early", bias_settled, 32'h0);
        repeat (260) @(posedge pclk);
        chk("bias", bias_settled, 32'h1);
        $display("Test chip enable method done");
        // Initialization method.
        wd = w(2'h3, 0, 0, 0, 1, 12'h0F0);
        xfer(wd);
        chk("init func", {10'h0, func_latch[23:2]}, {10'h0, wd[23:2]});
        chk("init pulse", pulse_cnt, 32'h1);
        chk("hiz on", charge_pump_hiz, 32'h1);
        xfer(w(2'h2, 0, 0, 0, 0, 12'h0F1));
        chk("hiz off", charge_pump_hiz, 32'h0);
        xfer(w(2'h0, 0, 0, 0, 0, 12'h0AA));
        chk("ref no pulse", pulse_cnt, 32'h1);
        xfer(w(2'h1, 0, 0, 0, 0, 12'h155));
        chk("fb pulse", pulse_cnt, 32'h2);
        xfer(w(2'h1, 0, 0, 0, 0, 12'h156));
        chk("fb again", pulse_cnt, 32'h2);
        chk("fb2", {8'h0, fb_latch}, {8'h0, w(2'h1, 0, 0, 0, 0, 12'h156)});
        $display("Test initialization method done");
        // Counter-clear method.
        xfer(w(2'h2, 1, 1, 0, 0, 12'h0F1));
        chk("hold", counter_hold, 32'h1);
        chk("hold hiz", charge_pump_hiz, 32'h1);
        chk("no sync pd", power_down, 32'h0);
        xfer(w(2'h0, 0, 0, 0, 0, 12'h0AB));
        xfer(w(2'h1, 0, 0, 0, 0, 12'h157));
        xfer(w(2'h2, 0, 0, 0, 0, 12'h0F1));
        chk("release", counter_hold, 32'h0);
        chk("pump on", charge_pump_hiz, 32'h0);
        $display("Test counter clear method done");
        // Synchronous power-down from the initialization pulse.
        xfer(w(2'h3, 0, 1, 0, 0, 12'h0F2));
        chk("sync pd", power_down, 32'h1);
        chk("pd hiz", charge_pump_hiz, 32'h1);
        xfer(w(2'h2, 0, 0, 0, 0, 12'h0F2));
        chk("sync pd off", power_down, 32'h0);
        // Chip enable low overrides and latches survive it.
        chip_enable <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("ce pd", power_down, 32'h1);
        chip_enable <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("ref kept", {8'h0, ref_latch}, {8'h0, w(2'h0, 0, 0, 0, 0, 12'h0AB)});
        $display("Test power down done");
        // Shifting without a strobe touches only the input register.
        wd = w(2'h0, 0, 0, 0, 0, 12'hE01);
        @(posedge pclk);
        i_ssl_host.send(wd, 1'b0);
        repeat (8) @(posedge pclk);
        chk("no load", {8'h0, ref_latch}, {8'h0, w(2'h0, 0, 0, 0, 0, 12'h0AB)});
        apb(SSL_OFS_WORD, 1'b0, 32'h0);
        chk("word", rd, {8'h0, wd});
        apb(SSL_OFS_CTRL, 1'b1, 32'h0);
        xfer(w(2'h0, 0, 0, 0, 0, 12'hE02));
        chk("disabled", {8'h0, ref_latch}, {8'h0, w(2'h0, 0, 0, 0, 0, 12'h0AB)});
        apb(SSL_OFS_CTRL, 1'b1, 32'h1);
        xfer(w(2'h0, 0, 0, 0, 0, 12'hE03));
        chk("enabled", {8'h0, ref_latch}, {8'h0, w(2'h0, 0, 0, 0, 0, 12'hE03)});
        // Fifteen strobes landed while shifting was enabled.
        apb(SSL_OFS_LOADS, 1'b0, 32'h0);
        chk("loads", rd, 32'h0000000F);
        // Enable seen high, bias settled, first feedback load still pending.
        apb(SSL_OFS_STATUS, 1'b0, 32'h0);
        chk("status", rd, 32'h00000064);
        $display("Test input register done");
        end_sim();
    end
endmodule
